// File: sar_adc_lvds_serial_output.sv
// converter control and serial output lanes
`include "sar_defs.svh"
// Summary of operation
// - low sleep_control_n forces the sleep state, blocks new conversions and turns off every output driver.
// - high pattern_force puts a fixed pattern on the lanes instead of the result.
// - in single-lane mode lane b is idle and its driver is disabled.
// - dual_lane_select high sends two bits per shift clock, else one bit on lane a.
// - echoed_bit_clock follows the incoming shift clock with a small delay.
// - a rising convert_strobe puts the sample into hold and starts a conversion.
// - acquisition alternates with conversion, which resolves bits down to 1/262144.
// - a finished conversion loads its 18-bit result for shifting with no latency.
// - results are two's complement across 2^18 codes.
// - each result goes out before the next conversion's result.
// - the result is ready for shifting about 20 clk_sys cycles after a conversion starts; the check allows 2 * WIDTH.
module sar_adc_lvds_serial_output
    import sar_pkg::*;
#(
    parameter int WIDTH = `RES_BITS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic sleep_control_n,
    input wire logic pattern_force,
    input wire logic dual_lane_select,
    input wire logic convert_strobe,
    input wire logic shift_clock,
    input wire logic comp_above,
    output logic sample_hold,
    output logic [WIDTH-1:0] dac_trial,
    output logic lane_a_data,
    output logic lane_a_oe,
    output logic lane_b_data,
    output logic lane_b_oe,
    output logic echoed_bit_clock,
    output logic echoed_clock_oe
);
    import sar_pkg::*;

    initial begin
        if (WIDTH != `RES_BITS) $error("width must match result size");
    end

    conv_state_e state_r, state_nxt;
    logic sleep_meta_r, awake_r;
    logic pat_meta_r, pat_r;
    logic dual_meta_r, dual_r;
    logic cnv_lvl, cnv_rise, sck_lvl, sck_rise, sck_fall;
    logic [WIDTH-1:0] code, shreg_r, trial;
    logic done;
    logic hold_r, a_r, b_r, aoe_r, boe_r, dco_r, dcoe_r;
    logic [`CTR_W-1:0] ready_cnt_r;

    // level inputs from pins pass two flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sleep_meta_r <= 1'b0;
            awake_r <= 1'b0;
            pat_meta_r <= 1'b0;
            pat_r <= 1'b0;
            dual_meta_r <= 1'b0;
            dual_r <= 1'b0;
        end else if (ce) begin
            sleep_meta_r <= sleep_control_n;
            awake_r <= sleep_meta_r;
            pat_meta_r <= pattern_force;
            pat_r <= pat_meta_r;
            dual_meta_r <= dual_lane_select;
            dual_r <= dual_meta_r;
        end
    end

    sync_edge u_cnv (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .din(convert_strobe),
        .level(cnv_lvl),
        .rise(cnv_rise),
        .fall()
    );

    // shift clock edges found by sampling; link clock is slow against clk_sys
    sync_edge u_sck (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .din(shift_clock),
        .level(sck_lvl),
        .rise(sck_rise),
        .fall(sck_fall)
    );

    wire conv_start = awake_r && cnv_rise;

    sar_engine #(
        .WIDTH(WIDTH)
    ) u_sar (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .start(conv_start),
        .comp_above(comp_above),
        .trial(trial),
        .code(code),
        .done(done)
    );

    // acquisition and conversion alternate
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_SLEEP: if (awake_r) state_nxt = ST_ACQ;
            ST_ACQ: if (conv_start) state_nxt = ST_CONV;
            ST_CONV: if (done) state_nxt = ST_ACQ;
            default: state_nxt = ST_SLEEP;
        endcase
        if (!awake_r) state_nxt = ST_SLEEP;
    end

    wire [WIDTH-1:0] load_word = pat_r ? `TEST_PATTERN : code;
    wire shift_step = sck_rise && awake_r;
    wire [WIDTH-1:0] shifted = dual_r ? {shreg_r[WIDTH-3:0], 2'b00}
                                      : {shreg_r[WIDTH-2:0], 1'b0};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= ST_SLEEP;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ready counter only feeds the timing check
    always_ff @(posedge clk_sys) begin
        if (rst || !ce) begin
            if (rst) ready_cnt_r <= '0;
        end else if (conv_start) begin
            ready_cnt_r <= '0;
        end else if (state_r == ST_CONV) begin
            ready_cnt_r <= ready_cnt_r + 1'b1;
        end
    end

    // result loads straight into the shifter, no pipeline
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shreg_r <= '0;
        end else if (ce) begin
            if (done) begin
                shreg_r <= load_word;
            end else if (shift_step) begin
                shreg_r <= shifted;
            end
        end
    end

    // output flops; drivers off while asleep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_r <= 1'b0;
            a_r <= 1'b0;
            b_r <= 1'b0;
            aoe_r <= 1'b0;
            boe_r <= 1'b0;
            dco_r <= 1'b0;
            dcoe_r <= 1'b0;
        end else if (ce) begin
            hold_r <= (state_nxt == ST_CONV);
            a_r <= awake_r & shreg_r[WIDTH-1];
            b_r <= awake_r & dual_r & shreg_r[WIDTH-2];
            aoe_r <= awake_r;
            boe_r <= awake_r & dual_r;
            dco_r <= awake_r & sck_lvl;
            dcoe_r <= awake_r;
        end
    end

    assign sample_hold = hold_r;
    // trial goes out straight from the engine flop: an extra stage would pair
    // each comparator answer with the wrong trial
    assign dac_trial = trial;
    assign lane_a_data = a_r;
    assign lane_a_oe = aoe_r;
    assign lane_b_data = b_r;
    assign lane_b_oe = boe_r;
    assign echoed_bit_clock = dco_r;
    assign echoed_clock_oe = dcoe_r;

    a_lane_b_off: assert property (@(posedge clk_sys) disable iff (rst)
        !dual_r |-> ##1 !lane_b_oe) else $error("lane b driven in one-lane mode");
    a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        !awake_r && ce |-> ##1 !lane_a_oe && !echoed_clock_oe)
        else $error("drivers on while asleep");
    a_echo_follow: assert property (@(posedge clk_sys) disable iff (rst)
        ce && awake_r |-> ##1 echoed_bit_clock == $past(sck_lvl))
        else $error("echo clock does not follow");
    a_hold_start: assert property (@(posedge clk_sys) disable iff (rst)
        conv_start && ce |-> ##1 sample_hold) else $error("no hold on strobe");
    a_conv_ends: assert property (@(posedge clk_sys) disable iff (rst)
        conv_start && ce |-> ##[1:40] done || !awake_r) else $error("conversion stuck");
    a_pattern_load: assert property (@(posedge clk_sys) disable iff (rst)
        done && ce && pat_r |-> ##1 shreg_r == `TEST_PATTERN)
        else $error("pattern not loaded");
    a_result_load: assert property (@(posedge clk_sys) disable iff (rst)
        done && ce && !pat_r |-> ##1 shreg_r == $past(code)) else $error("result lost");
    a_msb_first: assert property (@(posedge clk_sys) disable iff (rst)
        ce && awake_r |-> ##1 lane_a_data == $past(shreg_r[WIDTH-1]))
        else $error("lane a not msb");
    a_dual_step: assert property (@(posedge clk_sys) disable iff (rst)
        ce && shift_step && !done && dual_r |-> ##1 shreg_r[WIDTH-1] == $past(shreg_r[WIDTH-3]))
        else $error("dual shift wrong");
    a_ready_time: assert property (@(posedge clk_sys) disable iff (rst)
        done |-> ready_cnt_r <= `CTR_W'(2 * WIDTH)) else $error("ready too late");
endmodule : sar_adc_lvds_serial_output

// File: sar_defs.svh
// shared constants for the successive-approximation converter block
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH
`define RES_BITS 18
`define T_READY_NS 63
`define CLK_PERIOD_NS 20
`define READY_CYCLES ((`T_READY_NS) / (`CLK_PERIOD_NS))
`define TEST_PATTERN 18'h0C0F3
`define CTR_W 6
`endif

// File: sar_pkg.sv
// package of types for the converter block
`include "sar_defs.svh"
package sar_pkg;
    typedef enum logic [2:0] {
        ST_SLEEP = 3'b001,
        ST_ACQ = 3'b010,
        ST_CONV = 3'b100
    } conv_state_e;
    typedef logic [`RES_BITS-1:0] code_t;
endpackage : sar_pkg

// File: sync_edge.sv
// two-flop synchroniser with rise and fall detection
module sync_edge (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;
    // first flop read only by the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (ce) begin
            meta_r <= din;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    assign level = sync_r;
    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;
endmodule : sync_edge

// File: sar_engine.sv
// successive-approximation search over an external comparator
`include "sar_defs.svh"
module sar_engine #(
    parameter int WIDTH = `RES_BITS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic comp_above,
    output logic [WIDTH-1:0] trial,
    output logic [WIDTH-1:0] code,
    output logic done
);
    logic [WIDTH-1:0] trial_r;
    logic [WIDTH-1:0] bit_r;
    logic [WIDTH-1:0] code_r;
    logic done_r;
    initial begin
        if (WIDTH < 2) $error("sar width too small");
    end
    // one bit resolved per cycle, msb weight first (half span) down to 1/2^WIDTH
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trial_r <= '0;
            bit_r <= '0;
            code_r <= '0;
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= 1'b0;
            if (start) begin
                bit_r <= {1'b1, {(WIDTH-1){1'b0}}};
                trial_r <= {1'b1, {(WIDTH-1){1'b0}}};
            end else if (bit_r != '0) begin
                if (!comp_above) begin
                    trial_r <= (trial_r & ~bit_r) | (bit_r >> 1);
                end else begin
                    trial_r <= trial_r | (bit_r >> 1);
                end
                bit_r <= bit_r >> 1;
                if (bit_r[0]) begin
                    // offset binary to two's complement: flip msb
                    code_r <= (comp_above ? trial_r : (trial_r & ~bit_r))
                        ^ {1'b1, {(WIDTH-1){1'b0}}};
                    done_r <= 1'b1;
                end
            end
        end
    end
    assign trial = trial_r;
    assign code = code_r;
    assign done = done_r;
endmodule : sar_engine

// File: lvds_capture_host.sv
// far-side host model: shift clock source and serial word capture
module lvds_capture_host (
    input wire logic lane_a_data,
    input wire logic lane_b_data,
    input wire logic echoed_bit_clock,
    output logic shift_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    import sar_pkg::*;
    int n_echo = 0;
    initial begin
        shift_clock = 1'b0;
    end
    // echo rises counted so the bench can match them to shift edges
    always @(posedge echoed_bit_clock) begin
        n_echo <= n_echo + 1;
    end
    // clock runs only inside a word and rests low between frames
    task automatic read_word(input logic dual, output code_t ob, output int echoes);
        code_t w;
        int n;
        int e0;
        w = '0;
        n = dual ? 9 : 18;
        e0 = n_echo;
        #7; // odd offset keeps the link clock out of phase with clk_sys
        for (int i = 0; i < n; i++) begin
            #80; // first rise lands well after the result is out
            if (dual) begin
                w = {w[15:0], lane_a_data, lane_b_data}; // lane a holds the higher bit
            end else begin
                w = {w[16:0], lane_a_data};
            end
            shift_clock = 1'b1;
            #80;
            shift_clock = 1'b0;
        end
        #100;
        echoes = n_echo - e0;
        ob = w ^ 18'h20000; // offset binary by msb inversion
    endtask : read_word
endmodule : lvds_capture_host

// File: sar_adc_lvds_serial_output_tb.sv
// self-checking bench for the converter control and serial lanes
`include "sar_defs.svh"
module sar_adc_lvds_serial_output_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sleep_control_n = 1'b1;
    logic pattern_force = 1'b0;
    logic dual_lane_select = 1'b0;
    logic convert_strobe = 1'b0;
    logic shift_clock, comp_above, sample_hold, lane_a_data, lane_a_oe;
    logic lane_b_data, lane_b_oe, echoed_bit_clock, echoed_clock_oe;
    code_t dac_trial;
    code_t analog_level = '0;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_cycles = 0;
    always #10 clk_sys = ~clk_sys;
    // comparator stands in for the analog front end, offset binary scale
    assign comp_above = (analog_level >= dac_trial);
    sar_adc_lvds_serial_output dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .sleep_control_n(sleep_control_n), .pattern_force(pattern_force),
        .dual_lane_select(dual_lane_select), .convert_strobe(convert_strobe),
        .shift_clock(shift_clock), .comp_above(comp_above), .sample_hold(sample_hold),
        .dac_trial(dac_trial), .lane_a_data(lane_a_data), .lane_a_oe(lane_a_oe),
        .lane_b_data(lane_b_data), .lane_b_oe(lane_b_oe),
        .echoed_bit_clock(echoed_bit_clock), .echoed_clock_oe(echoed_clock_oe));
    lvds_capture_host host_u (.lane_a_data(lane_a_data), .lane_b_data(lane_b_data),
        .echoed_bit_clock(echoed_bit_clock), .shift_clock(shift_clock));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // hang guard, well above the roughly 1500 cycles the tests need
    always @(posedge clk_sys) begin
        n_cycles <= n_cycles + 1;
        if (n_cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // strobe, watch the hold phase end, then pull the word out
    task automatic convert(input code_t level, input logic dual, output code_t ob);
        int t;
        int echoes;
        logic seen;
        analog_level <= level;
        seen = 1'b0;
        @(posedge clk_sys);
        convert_strobe <= 1'b1;
        for (t = 1; t <= 40; t++) begin
            @(posedge clk_sys);
            #1;
            if (t == 4) begin
                convert_strobe <= 1'b0;
            end
            if (sample_hold === 1'b1) begin
                seen = 1'b1;
            end
            if (seen && sample_hold === 1'b0) begin
                break;
            end
        end
        check("hold phase", seen, 1'b1);
        check("ready bound", t <= 36, 1'b1);
        repeat (2) @(posedge clk_sys);
        host_u.read_word(dual, ob, echoes);
        check("echo count", echoes, dual ? 9 : 18);
        check("lane b enable", lane_b_oe, dual);
        check("echo enable", echoed_clock_oe, 1'b1);
    endtask : convert
    // boundary codes and one arbitrary code back to back in one-lane mode
    task automatic test_single();
        code_t lv[4] = '{18'h00000, 18'h3FFFF, 18'h20000, 18'h15A5C};
        code_t ob;
        foreach (lv[i]) begin
            convert(lv[i], 1'b0, ob);
            check("single word", ob, lv[i]);
        end
        $display("test single done");
    endtask : test_single
    task automatic test_dual();
        code_t lv[2] = '{18'h2AAAA, 18'h00001};
        code_t ob;
        dual_lane_select <= 1'b1;
        repeat (4) @(posedge clk_sys);
        foreach (lv[i]) begin
            convert(lv[i], 1'b1, ob);
            check("dual word", ob, lv[i]);
        end
        dual_lane_select <= 1'b0;
        repeat (4) @(posedge clk_sys);
        $display("test dual done");
    endtask : test_dual
    task automatic test_pattern();
        code_t ob;
        pattern_force <= 1'b1;
        repeat (4) @(posedge clk_sys);
        convert(18'h12345, 1'b0, ob);
        check("pattern word", ob, `TEST_PATTERN ^ 18'h20000);
        pattern_force <= 1'b0;
        repeat (4) @(posedge clk_sys);
        convert(18'h12345, 1'b0, ob);
        check("result after pattern", ob, 18'h12345);
        $display("test pattern done");
    endtask : test_pattern
    // strobes while asleep must not start a conversion
    task automatic test_sleep();
        code_t ob;
        int holds;
        holds = 0;
        sleep_control_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        convert_strobe <= 1'b1;
        repeat (8) begin
            @(posedge clk_sys);
            holds += (sample_hold !== 1'b0);
        end
        convert_strobe <= 1'b0;
        check("sleep hold", holds, 0);
        check("sleep drivers", {lane_a_oe, lane_b_oe, echoed_clock_oe}, 3'b000);
        sleep_control_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check("wake lane a", lane_a_oe, 1'b1);
        convert(18'h0F00F, 1'b0, ob);
        check("wake word", ob, 18'h0F00F);
        $display("test sleep done");
    endtask : test_sleep
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        test_single();
        test_dual();
        test_pattern();
        test_sleep();
        give_verdict();
    end
endmodule : sar_adc_lvds_serial_output_tb
